// ==== verilog/wwdt_map.svh ====
// Register offsets, field positions, reset values and timing counts of the watchdog.
// Included by the design files that decode or build the control and status words.
`ifndef WWDT_MAP_SVH
`define WWDT_MAP_SVH

`define WWDT_CTRL_OFS   12'h000
`define WWDT_CLR_OFS    12'h004
`define WWDT_STAT_OFS   12'h008
`define WWDT_VER_OFS    12'h3FC

`define WWDT_CTRL_RST   32'h00010080
`define WWDT_STAT_RST   32'h00000003

`define WWDT_KEY_FIRST  8'h55
`define WWDT_KEY_SECOND 8'hAA

`define WWDT_EN_BIT     0
`define WWDT_DAR_BIT    1
`define WWDT_MODE_BIT   2
`define WWDT_LOCK_BIT   3
`define WWDT_FCD_BIT    7
`define WWDT_PSEL_LSB   8
`define WWDT_PSEL_MSB   12
`define WWDT_CEN_BIT    16
`define WWDT_COUNT_CLOCK_SOURCE_BIT  17
`define WWDT_TBAN_LSB   18
`define WWDT_TBAN_MSB   22
`define WWDT_KEY_LSB    24
`define WWDT_KEY_MSB    31
`define WWDT_CLRBIT     0

`define WWDT_SYNC_CYC   2'h2

`endif

// ==== verilog/wwdt_pkg.sv ====
// Types shared by the watchdog design.
// Assumes an AXI4-Lite register bus.
package wwdt_pkg;
	typedef enum logic [1:0]
	{
		WWDT_OKAY   = 2'h0,
		WWDT_SLVERR = 2'h2
	} wwdt_resp_type;

	typedef logic [4:0] wwdt_presc_type;
endpackage

// ==== verilog/wwdt_top.sv ====
// Windowed watchdog counter with keyed control and clear registers on AXI4-Lite.
// Assumes the counter clock sources arrive as one-cycle tick pulses synchronous to clk_in,
// and that the reset manager reports in wd_cause_in whether the pending reset is a watchdog reset.
`timescale 1ns/1ns
`include "wwdt_map.svh"

// Overview of operation
// - Watchdog reset with disable-after-reset zero restarts counting from zero, still enabled.
// - Watchdog reset with disable-after-reset one clears only the enable and lock bits.
// - Fuse auto-enable with calibration-done zero ignores writing one to disable-after-reset.
// - Mode one is window, zero basic; mode changes only while disabled.
// - Window timeout is ban of 2^(ban+1) then open 2^(prescale+1) ticks.
// - A valid clear inside the ban interval requests watchdog reset and clears counter.
// - A valid clear inside the open interval restarts the counter from zero.
// - Any accepted control value change clears the counter without watchdog reset.
// - Reaching full timeout clears the counter and requests a watchdog reset.
// - With counter clock gate zero, enable never falls from one to zero.
// - Fuse set gives enabled, basic mode, RC clock, long prescale after reset.
// - Calibration redone unless watchdog reset with calibration-done one; bit set afterwards.
// - Lock bit set blocks control writes until any reset.
// - Protected registers need a 0x55 then 0xAA keyed pair; key reads zero.
// - Clear bit zero does nothing; valid keyed one clears the counter.
// - Clock source select zero picks RC oscillator, one the crystal oscillator.
// - Counter clock gate zero stops counter clock; resets to one.
// - Enable read-back changes only after the counter side really switched.
// - Calibration-done bit sits at bit 7 and resets to one.
// - Status in-window flag is zero in ban interval, one in open interval.
// - Cleared flag drops on clear write, rises when done; clears while zero ignored.
// - Basic timeout is 2^(prescale+1) ticks; clear allowed any time.
module wwdt_top
#(
	parameter logic [4:0]  FUSE_PSEL     = 5'h11,
	// Arbitrary identification value.
	parameter logic [31:0] VERSION_VALUE = 32'h00000100
)
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// AXI4-Lite write
	input  wire logic [11:0] s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	// AXI4-Lite read
	input  wire logic [11:0] s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// Counter clock ticks and system side
	input  wire logic        system_rc_osc_tick_in,
	input  wire logic        crystal_slow_osc_tick_in,
	input  wire logic        fuse_auto_enable_in,
	input  wire logic        wd_cause_in,
	input  wire logic        flash_cal_finished_in,
	output logic             wd_reset_req_out,
	output logic             count_clock_source_out,
	output logic             count_clock_gate_out,
	output logic             flash_cal_req_out
);

	////////////////////////////////////////////////////////////////////////////////
	logic                   en;
	logic                   en_active;
	logic                   disable_after_wd_reset;
	logic                   mode;
	logic                   lock;
	logic                   fcd;
	wwdt_pkg::wwdt_presc_type psel;
	wwdt_pkg::wwdt_presc_type tban;
	logic                   count_clock_gate;
	logic                   count_clock_source;
	logic                   ctrl_arm;
	logic [23:0]            ctrl_arm_data;
	logic                   clr_arm;
	logic                   cleared;
	logic                   clr_busy;
	logic [1:0]             clr_cnt;
	logic [1:0]             en_cnt;
	logic [31:0]            cnt;
	logic                   wd_req;
	logic                   recal;
	logic                   wr_fire;
	logic                   wr_full;
	logic                   ctrl_wr;
	logic                   ctrl_ok;
	logic                   ctrl_changed;
	logic                   clr_wr;
	logic                   clr_ok;
	logic                   clr_apply;
	logic                   tick;
	logic                   timeout;
	logic                   in_window;
	logic                   rst_en;
	logic                   fcd_rd;
	logic                   next_mode;
	logic                   next_dar;
	logic [33:0]            ban_len;
	logic [33:0]            psel_len;
	logic [33:0]            total_len;
	logic [7:0]             wkey;
	logic [31:0]            ctrl_rd;
	localparam logic [31:0] CTRL_RESET = `WWDT_CTRL_RST;

	////////////////////////////////////////////////////////////////////////////////
	// Both write channels are taken together, so a write is one decision in one cycle.
	assign wr_fire           = s_axi_awvalid_in && s_axi_wvalid_in && !s_axi_bvalid_out;
	assign s_axi_awready_out = wr_fire;
	assign s_axi_wready_out  = wr_fire;
	assign s_axi_arready_out = !s_axi_rvalid_out;
	assign wr_full           = s_axi_wstrb_in == 4'hF;
	assign wkey              = s_axi_wdata_in[`WWDT_KEY_MSB:`WWDT_KEY_LSB];
	assign ctrl_wr           = wr_fire && wr_full && s_axi_awaddr_in == `WWDT_CTRL_OFS;
	assign clr_wr            = wr_fire && wr_full && s_axi_awaddr_in == `WWDT_CLR_OFS;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= wwdt_pkg::WWDT_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid_out <= 1'b1;
			if (s_axi_awaddr_in == `WWDT_CTRL_OFS || s_axi_awaddr_in == `WWDT_CLR_OFS)
				s_axi_bresp_out <= wwdt_pkg::WWDT_OKAY;
			else
				s_axi_bresp_out <= wwdt_pkg::WWDT_SLVERR;
		end
		else if (s_axi_bready_in)
			s_axi_bvalid_out <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// The key byte is not stored, so it always reads back as zero.
	assign fcd_rd  = fcd && !recal;
	assign ctrl_rd = {8'h00, 1'b0, tban, count_clock_source, count_clock_gate, 3'h0, psel, fcd_rd, 3'h0, lock, mode, disable_after_wd_reset,
		en_active};

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out  <= 32'h00000000;
			s_axi_rresp_out  <= wwdt_pkg::WWDT_OKAY;
		end
		else if (s_axi_arvalid_in && !s_axi_rvalid_out)
		begin
			s_axi_rvalid_out <= 1'b1;
			s_axi_rresp_out  <= wwdt_pkg::WWDT_OKAY;
			case (s_axi_araddr_in)
				`WWDT_CTRL_OFS: s_axi_rdata_out <= ctrl_rd;
				`WWDT_CLR_OFS:  s_axi_rdata_out <= 32'h00000000;
				`WWDT_STAT_OFS: s_axi_rdata_out <= {30'h0, cleared, in_window};
				`WWDT_VER_OFS:  s_axi_rdata_out <= VERSION_VALUE;
				default:
				begin
					s_axi_rdata_out <= 32'h00000000;
					s_axi_rresp_out <= wwdt_pkg::WWDT_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready_in)
			s_axi_rvalid_out <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Keyed control write: the second half must carry the same low bits as the first.
	assign ctrl_ok = ctrl_wr && ctrl_arm && wkey == `WWDT_KEY_SECOND && !lock
		&& s_axi_wdata_in[23:0] == ctrl_arm_data;
	assign next_mode = en_active ? mode : s_axi_wdata_in[`WWDT_MODE_BIT];
	assign next_dar  = (fuse_auto_enable_in && !fcd_rd && s_axi_wdata_in[`WWDT_DAR_BIT]) ? disable_after_wd_reset
		: s_axi_wdata_in[`WWDT_DAR_BIT];
	assign ctrl_changed = ctrl_ok && {next_mode, next_dar, s_axi_wdata_in[`WWDT_EN_BIT],
		s_axi_wdata_in[`WWDT_LOCK_BIT], s_axi_wdata_in[`WWDT_FCD_BIT],
		s_axi_wdata_in[`WWDT_PSEL_MSB:`WWDT_PSEL_LSB], s_axi_wdata_in[`WWDT_CEN_BIT],
		s_axi_wdata_in[`WWDT_COUNT_CLOCK_SOURCE_BIT], s_axi_wdata_in[`WWDT_TBAN_MSB:`WWDT_TBAN_LSB]}
		!= {mode, disable_after_wd_reset, en, lock, fcd, psel, count_clock_gate, count_clock_source, tban};
	assign rst_en = wd_cause_in ? (en && !disable_after_wd_reset) : fuse_auto_enable_in;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			ctrl_arm      <= 1'b0;
			ctrl_arm_data <= 24'h000000;
			lock          <= 1'b0;
			fcd           <= 1'b1;
			en            <= rst_en;
			if (!wd_cause_in)
			begin
				disable_after_wd_reset   <= CTRL_RESET[`WWDT_DAR_BIT];
				mode  <= 1'b0;
				count_clock_gate   <= 1'b1;
				count_clock_source <= 1'b0;
				tban  <= 5'h00;
				psel  <= fuse_auto_enable_in ? FUSE_PSEL : 5'h00;
			end
		end
		else
		begin
			if (ctrl_wr)
			begin
				ctrl_arm      <= wkey == `WWDT_KEY_FIRST;
				ctrl_arm_data <= s_axi_wdata_in[23:0];
			end
			if (ctrl_ok)
			begin
				en    <= s_axi_wdata_in[`WWDT_EN_BIT];
				disable_after_wd_reset   <= next_dar;
				mode  <= next_mode;
				lock  <= s_axi_wdata_in[`WWDT_LOCK_BIT];
				fcd   <= s_axi_wdata_in[`WWDT_FCD_BIT];
				psel  <= s_axi_wdata_in[`WWDT_PSEL_MSB:`WWDT_PSEL_LSB];
				count_clock_gate   <= s_axi_wdata_in[`WWDT_CEN_BIT];
				count_clock_source <= s_axi_wdata_in[`WWDT_COUNT_CLOCK_SOURCE_BIT];
				tban  <= s_axi_wdata_in[`WWDT_TBAN_MSB:`WWDT_TBAN_LSB];
			end
		end
	end

	// Flash calibration is skipped only after a watchdog reset with the done bit set.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			recal <= !(wd_cause_in && fcd_rd);
		else if (flash_cal_finished_in)
			recal <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Enable crosses to the counter side only while its clock runs; with the gate off a
	// pending disable stalls, so the read-back keeps showing one.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			en_active <= rst_en;
			en_cnt    <= 2'h0;
		end
		else if (en != en_active && count_clock_gate)
		begin
			if (en_cnt == `WWDT_SYNC_CYC - 2'h1)
			begin
				en_active <= en;
				en_cnt    <= 2'h0;
			end
			else
				en_cnt <= en_cnt + 2'h1;
		end
		else
			en_cnt <= 2'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Keyed clear: first half must already carry a one in the clear bit.
	assign clr_ok = clr_wr && clr_arm && wkey == `WWDT_KEY_SECOND
		&& s_axi_wdata_in[`WWDT_CLRBIT] && cleared;
	assign clr_apply = clr_busy && clr_cnt == `WWDT_SYNC_CYC - 2'h1;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			clr_arm  <= 1'b0;
			cleared  <= 1'b1;
			clr_busy <= 1'b0;
			clr_cnt  <= 2'h0;
		end
		else
		begin
			if (clr_wr)
				clr_arm <= wkey == `WWDT_KEY_FIRST && s_axi_wdata_in[`WWDT_CLRBIT];
			if (clr_ok)
			begin
				cleared  <= 1'b0;
				clr_busy <= 1'b1;
				clr_cnt  <= 2'h0;
			end
			else if (clr_apply)
			begin
				cleared  <= 1'b1;
				clr_busy <= 1'b0;
			end
			else if (clr_busy)
				clr_cnt <= clr_cnt + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Lengths are 34 bits wide so that the largest prescale never wraps the comparison;
	// a window total beyond the 32-bit counter range can never be reached.
	assign ban_len   = 34'h1 << ({1'b0, tban} + 6'h01);
	assign psel_len  = 34'h1 << ({1'b0, psel} + 6'h01);
	assign total_len = mode ? ban_len + psel_len : psel_len;
	assign in_window = !mode || !en_active || {2'h0, cnt} >= ban_len;
	assign tick      = en_active && count_clock_gate && (count_clock_source ? crystal_slow_osc_tick_in
		: system_rc_osc_tick_in);
	assign timeout   = tick && {2'h0, cnt} + 34'h1 >= total_len;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			cnt <= 32'h00000000;
		else if (ctrl_changed || clr_apply || timeout)
			cnt <= 32'h00000000;
		else if (tick)
			cnt <= cnt + 32'h00000001;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			wd_req <= 1'b0;
		else if (timeout || (clr_apply && !in_window))
			wd_req <= 1'b1;
	end

	assign wd_reset_req_out       = wd_req;
	assign count_clock_source_out = count_clock_source;
	assign count_clock_gate_out   = count_clock_gate;
	assign flash_cal_req_out      = recal;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	sequence s_clr_taken;
		clr_ok;
	endsequence
	sequence s_clr_done;
		##[1:3] (cleared && cnt == 32'h00000000);
	endsequence

	property p_clear_done;
		s_clr_taken |-> s_clr_done;
	endproperty
	a_clear_done: assert property (p_clear_done) else $error("clear did not complete");

	property p_lock;
		lock |=> $stable({mode, disable_after_wd_reset, psel, tban, count_clock_gate, count_clock_source}) && lock;
	endproperty
	a_lock: assert property (p_lock) else $error("locked control changed");

	property p_mode;
		en_active |=> $stable(mode);
	endproperty
	a_mode: assert property (p_mode) else $error("mode changed while enabled");

	property p_timeout;
		timeout |=> wd_req && cnt == 32'h00000000;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout without reset request");

	property p_ban;
		clr_apply && mode && en_active && {2'h0, cnt} < ban_len |=> wd_req && cnt == 32'h00000000;
	endproperty
	a_ban: assert property (p_ban) else $error("ban clear did not fire");

	property p_hold;
		wd_req |=> wd_req;
	endproperty
	a_hold: assert property (p_hold) else $error("reset request dropped");

	property p_gate;
		!count_clock_gate && en_active && !en |=> en_active;
	endproperty
	a_gate: assert property (p_gate) else $error("disable finished with clock gated");

	property p_change;
		ctrl_changed && !wd_req && !timeout |=> cnt == 32'h00000000 && !wd_req;
	endproperty
	a_change: assert property (p_change) else $error("control change did not clear");

	property p_key_read;
		s_axi_arvalid_in && !s_axi_rvalid_out && s_axi_araddr_in == `WWDT_CTRL_OFS
			|=> s_axi_rdata_out[31:24] == 8'h00;
	endproperty
	a_key_read: assert property (p_key_read) else $error("key byte read nonzero");

	property p_window;
		mode && en_active && cnt == 32'h00000000 |-> !in_window;
	endproperty
	a_window: assert property (p_window) else $error("window flag set in ban");

	property p_sync;
		$rose(en) && !en_active && count_clock_gate ##1 count_clock_gate |-> !en_active;
	endproperty
	a_sync: assert property (p_sync) else $error("enable read-back too early");
endmodule

// ==== bench/wwdt_partner.sv ====
// Model of the reset manager, oscillators and flash calibration around the watchdog.
// Assumes one clock; ticks are one-cycle pulses and resets are synchronous.
`timescale 1ns/1ns
module wwdt_partner
(
	// Clock and power-on request
	input  wire logic clk_in,
	input  wire logic por_in,
	// From the watchdog
	input  wire logic wd_reset_req_in,
	input  wire logic flash_cal_req_in,
	// To the watchdog, and the watchdog reset count to the bench
	output logic      rst_out,
	output logic      wd_cause_out,
	output logic      rc_tick_out,
	output logic      xtal_tick_out,
	output logic      cal_done_out,
	output int        wd_resets_out
);
	logic [3:0] div = 4'h0;
	logic [3:0] hold = 4'h0;
	logic [3:0] cal = 4'h0;
	int         resets = 0;

	initial
	begin
		wd_cause_out = 1'b0;
		rc_tick_out = 1'b0;
		xtal_tick_out = 1'b0;
		cal_done_out = 1'b0;
	end

	assign rst_out = por_in | (hold != 4'h0);
	assign wd_resets_out = resets;

	////////////////////////////////////////////////////////////////////////////////
	// The crystal ticks four times slower than the RC source.
	always @(posedge clk_in)
	begin
		div <= div + 4'h1;
		rc_tick_out <= (div[1:0] == 2'h3);
		xtal_tick_out <= (div == 4'hF);
	end

	////////////////////////////////////////////////////////////////////////////////
	// A request is answered by a short reset that is flagged as a watchdog reset.
	always @(posedge clk_in)
	begin
		if (por_in)
		begin
			hold <= 4'h0;
			wd_cause_out <= 1'b0;
		end
		else if (wd_reset_req_in === 1'b1 && hold == 4'h0)
		begin
			hold <= 4'h3;
			wd_cause_out <= 1'b1;
			resets <= resets + 1;
		end
		else if (hold != 4'h0)
			hold <= hold - 4'h1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Calibration runs only outside reset and finishes with a one-cycle pulse.
	always @(posedge clk_in)
	begin
		cal <= (flash_cal_req_in === 1'b1 && !rst_out) ? cal + 4'h1 : 4'h0;
		cal_done_out <= (flash_cal_req_in === 1'b1) && (cal == 4'hE);
	end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench of the watchdog over AXI4-Lite.
// Assumes the partner model supplies reset, ticks and calibration.
`timescale 1ns/1ns
module testbench;
	localparam logic [31:0] VER = 32'h00000123;
	logic        clk_in;
	logic        por = 1'b1, fuse = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, rst, cause, rc, xt, caldone, req, src, gate, calreq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata, d;
	logic [1:0]  r;
	int          wdc, fail_count = 0, tests_run = 0;

	wwdt_top #(.FUSE_PSEL(5'h11), .VERSION_VALUE(VER)) dut_u (.clk_in(clk_in), .rst_in(rst),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.system_rc_osc_tick_in(rc), .crystal_slow_osc_tick_in(xt), .fuse_auto_enable_in(fuse),
		.wd_cause_in(cause), .flash_cal_finished_in(caldone), .wd_reset_req_out(req),
		.count_clock_source_out(src), .count_clock_gate_out(gate), .flash_cal_req_out(calreq));

	wwdt_partner partner_u (.clk_in(clk_in), .por_in(por), .wd_reset_req_in(req), .flash_cal_req_in(calreq),
		.rst_out(rst), .wd_cause_out(cause), .rc_tick_out(rc), .xtal_tick_out(xt), .cal_done_out(caldone),
		.wd_resets_out(wdc));

	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge clk_in);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk_in); while (!(awready === 1'b1 && wready === 1'b1));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk_in); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_in); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_in); while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	// Keyed pair: the same low bits behind each of the two keys.
	task automatic kw(input logic [11:0] a, input logic [31:0] v);
		logic [1:0] rs;
		wr(a, {8'h55, v[23:0]}, rs);
		wr(a, {8'hAA, v[23:0]}, rs);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  rs;
		rd(a, v, rs);
		chk(v, e);
	endtask

	// Enable and cleared flags settle after a synchronisation delay, so they are polled.
	task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  rs;
		int          n;
		n = 0;
		do
		begin
			rd(a, v, rs);
			n++;
		end
		while ((v & m) !== e && n < 40);
		chk(v & m, e);
	endtask

	task automatic wait_rst(input int lim);
		int c0;
		c0 = wdc;
		repeat (lim) if (wdc == c0) @(posedge clk_in);
		cyc(6);
	endtask

	task automatic por_rst;
		@(posedge clk_in);
		por <= 1'b1;
		cyc(12);
		por <= 1'b0;
		cyc(40);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#40000;
		fail_count++;
		wrap_up;
	end

	initial
	begin
		por_rst;
		rdc(12'h000, 32'h00010080);
		rdc(12'h008, 32'h00000003);
		rdc(12'h3FC, VER);
		rd(12'h00C, d, r);
		chk({30'h0, r}, 32'h2);
		chk(d, 32'h0);
		wr(12'h010, 32'h0, r);
		chk({30'h0, r}, 32'h2);
		chk({30'h0, src, gate}, 32'h1);
		wr(12'h000, 32'hAA000281, r);
		rdc(12'h000, 32'h00010080);
		wr(12'h000, 32'h55000281, r);
		wr(12'h000, 32'hAA000283, r);
		rdc(12'h000, 32'h00010080);
		kw(12'h000, 32'h00010281);
		poll(12'h000, 32'hFFFFFFFF, 32'h00010281);
		wait_rst(60);
		chk(wdc, 1);
		chk({31'h0, calreq}, 32'h0);
		rdc(12'h000, 32'h00010281);
		repeat (10)
		begin
			kw(12'h004, 32'h1);
			cyc(6);
		end
		chk(wdc, 1);
		repeat (2)
		begin
			kw(12'h004, 32'h0);
			cyc(6);
		end
		wait_rst(40);
		chk(wdc, 2);
		kw(12'h000, 32'h00010280);
		poll(12'h000, 32'h1, 32'h0);
		kw(12'h000, 32'h00090285);
		poll(12'h000, 32'h1, 32'h1);
		kw(12'h000, 32'h00090281);
		rdc(12'h000, 32'h00090285);
		kw(12'h004, 32'h1);
		wait_rst(20);
		chk(wdc, 3);
		rdc(12'h000, 32'h00090285);
		poll(12'h008, 32'h1, 32'h1);
		kw(12'h004, 32'h1);
		poll(12'h008, 32'h2, 32'h2);
		rd(12'h008, d, r);
		chk(d & 32'h1, 32'h0);
		cyc(40);
		chk(wdc, 3);
		wait_rst(40);
		chk(wdc, 4);
		kw(12'h000, 32'h00090287);
		wait_rst(100);
		chk(wdc, 5);
		rdc(12'h000, 32'h00090286);
		kw(12'h000, 32'h0009028E);
		rdc(12'h000, 32'h0009028E);
		kw(12'h000, 32'h00090286);
		rdc(12'h000, 32'h0009028E);
		fuse <= 1'b1;
		por_rst;
		rdc(12'h000, 32'h00011181);
		chk({30'h0, src, gate}, 32'h1);
		kw(12'h000, 32'h00001181);
		chk({31'h0, gate}, 32'h0);
		kw(12'h000, 32'h00001180);
		cyc(20);
		rdc(12'h000, 32'h00001181);
		por_rst;
		kw(12'h000, 32'h00011101);
		kw(12'h000, 32'h00011103);
		rdc(12'h000, 32'h00011101);
		kw(12'h000, 32'h00010201);
		wait_rst(60);
		chk(wdc, 6);
		chk({31'h0, calreq}, 32'h1);
		kw(12'h000, 32'h00010280);
		poll(12'h000, 32'h81, 32'h80);
		fuse <= 1'b0;
		por_rst;
		kw(12'h000, 32'h00030080);
		chk({30'h0, src, gate}, 32'h3);
		wrap_up;
	end
endmodule
